// ---- pkg/sfdp_map.svh ----
// Offsets, field positions, reset values and table bytes of the parameter map.
`ifndef SFDP_MAP_SVH
`define SFDP_MAP_SVH

// Register port offsets; the discovery window fills the low 256 bytes.
`define SFDP_WIN_TOP        12'h0_0FF
`define SFDP_OFS_CTRL       12'h0_100
`define SFDP_OFS_PTR        12'h0_101
`define SFDP_OFS_DATA       12'h0_102
`define SFDP_OFS_STAT       12'h0_103
`define SFDP_OFS_CMD        12'h0_104
`define SFDP_OFS_FOUND      12'h0_105
`define SFDP_OFS_LOC_LO     12'h0_106
`define SFDP_OFS_LOC_HI     12'h0_107

// Field positions.
`define SFDP_CTRL_MAP_EN    0
`define SFDP_CTRL_AUTO_INC  1
`define SFDP_STAT_WR_IGN    0
`define SFDP_STAT_BUSY      1
`define SFDP_STAT_DONE      2
`define SFDP_STAT_FAIL      3
`define SFDP_CMD_WALK       0

// Reset values.
`define SFDP_CTRL_RST       8'h01
`define SFDP_PTR_RST        8'h00
`define SFDP_FOUND_RST      8'h00

// Padding parameter contents, plus the read value of unmapped register offsets.
`define SFDP_PAD_ID         8'hF0
`define SFDP_PAD_LEN_DEF    8'h0F
`define SFDP_ERASED         8'hFF
`define SFDP_UNMAPPED       8'h00

// Discovery parameter header and basic table.
`define SFDP_PARAM_ID       8'hA5
`define SFDP_PARAM_LEN      8'h80
`define SFDP_HDR_BYTES      2
`define SFDP_TABLE_LOC      16'h1120
`define SFDP_TB_00          8'hE7
`define SFDP_TB_01          8'hFF
`define SFDP_TB_02          8'hF3
`define SFDP_TB_03          8'hFF
`define SFDP_TB_04          8'hFF
`define SFDP_TB_05          8'hFF
`define SFDP_TB_06          8'hFF
`define SFDP_TB_07          8'h07
`define SFDP_TB_08          8'h44
`define SFDP_TB_09          8'hEB
`define SFDP_TB_0A          8'h08
`define SFDP_TB_0B          8'h6B

`endif

// ---- pkg/sfdp_pkg.sv ----
// Types shared by the parameter table modules.
`default_nettype none
package sfdp_pkg;

  typedef logic [7:0] byte_t;

  // Self walk over the parameter map, one-hot coded.
  typedef enum logic [4:0] {
    W_IDLE = 5'b0_0001,
    W_ID   = 5'b0_0010,
    W_LEN  = 5'b0_0100,
    W_DONE = 5'b0_1000,
    W_FAIL = 5'b1_0000
  } walk_state_e;

endpackage
`default_nettype wire

// ---- logic/sfdp_map_byte.sv ----
// Combinational lookup of one byte of the parameter map by its index.
`include "sfdp_map.svh"
`default_nettype none
module sfdp_map_byte #(
  parameter int       PAD_NUM = 1,
  parameter bit [7:0] PAD_LEN = `SFDP_PAD_LEN_DEF
) (
  input  wire logic [7:0] idx,
  output logic      [7:0] data
);

  localparam int PAD_SPAN = int'(PAD_LEN) + 2;
  localparam int A5_BASE  = PAD_NUM * PAD_SPAN;
  localparam int A5_SPAN  = int'(`SFDP_PARAM_LEN) + 2;

  logic [PAD_NUM-1:0] pad_hit;
  sfdp_pkg::byte_t    pad_byte [PAD_NUM];
  logic [8:0]         a5_rel;
  logic [8:0]         tb_ofs;
  sfdp_pkg::byte_t    tb_byte;

  // Each padding parameter claims its own span ahead of the table.
  for (genvar g = 0; g < PAD_NUM; g++)
  begin : g_pad
    localparam int BASE = g * PAD_SPAN;
    logic [8:0] rel;
    assign rel = {1'b0, idx} - 9'(BASE);
    assign pad_hit[g] = ({1'b0, idx} >= 9'(BASE))
                        && (rel < 9'(PAD_SPAN));
    assign pad_byte[g] = (rel == 9'h000) ? `SFDP_PAD_ID :
                         (rel == 9'h001) ? PAD_LEN : `SFDP_ERASED;
  end

  assign a5_rel = {1'b0, idx} - 9'(A5_BASE);
  assign tb_ofs = a5_rel - 9'(`SFDP_HDR_BYTES);

  // Fixed contents; nothing here depends on any access history.
  always_comb
  begin
    unique case (tb_ofs)
      9'h000:  tb_byte = `SFDP_TB_00;
      9'h001:  tb_byte = `SFDP_TB_01;
      9'h002:  tb_byte = `SFDP_TB_02;
      9'h003:  tb_byte = `SFDP_TB_03;
      9'h004:  tb_byte = `SFDP_TB_04;
      9'h005:  tb_byte = `SFDP_TB_05;
      9'h006:  tb_byte = `SFDP_TB_06;
      9'h007:  tb_byte = `SFDP_TB_07;
      9'h008:  tb_byte = `SFDP_TB_08;
      9'h009:  tb_byte = `SFDP_TB_09;
      9'h00A:  tb_byte = `SFDP_TB_0A;
      9'h00B:  tb_byte = `SFDP_TB_0B;
      default: tb_byte = `SFDP_ERASED;
    endcase
  end

  // Pads first, then the discovery parameter, erased bytes elsewhere.
  always_comb
  begin
    data = `SFDP_ERASED;
    for (int i = 0; i < PAD_NUM; i++)
    begin
      if (pad_hit[i])
      begin
        data = pad_byte[i];
      end
    end
    if (({1'b0, idx} >= 9'(A5_BASE)) && (a5_rel < 9'(A5_SPAN)))
    begin
      if (a5_rel == 9'h000)
      begin
        data = `SFDP_PARAM_ID;
      end
      else if (a5_rel == 9'h001)
      begin
        data = `SFDP_PARAM_LEN;
      end
      else
      begin
        data = tb_byte;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/sfdp_param_table.sv ----
// Read-only discovery parameter table with its register port and self walk.
// What this block does
// - Padding parameters F0h reserve or align map space
// - Parameter byte 00h reads A5h
// - Byte 01h reads 80h, the following count
// - Basic table begins at byte 02h, 1120h
// - Table byte 00h reads E7h
// - Table byte 01h reads FFh, no erase opcode
// - Table byte 02h reads F3h, read modes
// - Table byte 03h reads all ones
// - Bytes 04h-07h give density 07FFFFFFh, LSB first
// - Table byte 08h reads 44h
// - Table byte 09h reads EBh opcode
// - Table byte 0Ah reads 08h
// - Table byte 0Bh reads 6Bh opcode
//
// Local design decisions: strobed register access and the register offsets.
`include "sfdp_map.svh"
`default_nettype none
module sfdp_param_table #(
  parameter int       PAD_NUM = 1,
  parameter bit [7:0] PAD_LEN = `SFDP_PAD_LEN_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  output logic             walk_busy
);

  // Address decode of the plain register port.
  logic in_win;
  logic hit_ctrl;
  logic hit_ptr;
  logic hit_data;
  logic hit_stat;
  logic hit_cmd;
  logic hit_found;
  logic hit_loc_lo;
  logic hit_loc_hi;

  // Table location as a named constant, so its bytes can be selected.
  localparam logic [15:0] TABLE_LOC = `SFDP_TABLE_LOC;

  // Software visible state.
  logic [7:0]           ctrl_q;
  logic [7:0]           ptr_q;
  logic                 wr_ign_q;
  logic                 done_q;
  logic                 fail_q;
  logic [7:0]           found_q;
  logic [7:0]           rdata_q;
  logic [7:0]           rdata_d;

  // Self walk state.
  sfdp_pkg::walk_state_e walk_q;
  sfdp_pkg::walk_state_e walk_d;
  logic [8:0]           loc_q;
  logic [8:0]           loc_d;
  logic [8:0]           next_loc;
  logic                 walk_start;
  logic                 walk_hit;
  logic                 walk_end;

  // Lookup ports into the constant map.
  logic [7:0]           bus_idx;
  logic [7:0]           bus_byte;
  logic [7:0]           walk_idx;
  logic [7:0]           walk_byte;
  logic                 map_en;
  logic                 auto_inc;
  logic                 data_rd;
  logic                 err_wr;

  // Window bytes sit at their map index; registers sit above the window.
  assign in_win     = (addr <= `SFDP_WIN_TOP);
  assign hit_ctrl   = (addr == `SFDP_OFS_CTRL);
  assign hit_ptr    = (addr == `SFDP_OFS_PTR);
  assign hit_data   = (addr == `SFDP_OFS_DATA);
  assign hit_stat   = (addr == `SFDP_OFS_STAT);
  assign hit_cmd    = (addr == `SFDP_OFS_CMD);
  assign hit_found  = (addr == `SFDP_OFS_FOUND);
  assign hit_loc_lo = (addr == `SFDP_OFS_LOC_LO);
  assign hit_loc_hi = (addr == `SFDP_OFS_LOC_HI);

  assign map_en   = ctrl_q[`SFDP_CTRL_MAP_EN];
  assign auto_inc = ctrl_q[`SFDP_CTRL_AUTO_INC];
  assign data_rd  = rd_en && hit_data;

  // A write aimed at table contents is refused; only a flag records it.
  assign err_wr = wr_en && (in_win || hit_data || hit_found
                            || hit_loc_lo || hit_loc_hi);

  // The window reads the addressed byte, the data port reads at the pointer.
  assign bus_idx = in_win ? addr[7:0] : ptr_q;

  sfdp_map_byte #(
    .PAD_NUM (PAD_NUM),
    .PAD_LEN (PAD_LEN)
  ) u_bus_map (
    .idx  (bus_idx),
    .data (bus_byte)
  );

  // The walk has its own lookup so it never disturbs bus reads.
  sfdp_map_byte #(
    .PAD_NUM (PAD_NUM),
    .PAD_LEN (PAD_LEN)
  ) u_walk_map (
    .idx  (walk_idx),
    .data (walk_byte)
  );

  // Control register: map enable and pointer auto increment.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ctrl_q <= `SFDP_CTRL_RST;
    end
    else if (wr_en && hit_ctrl)
    begin
      ctrl_q <= {6'h00, wdata[1:0]};
    end
  end

  // Byte pointer; a data read steps it when auto increment is on.
  // It wraps at the window size, matching an 8-bit index.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ptr_q <= `SFDP_PTR_RST;
    end
    else if (wr_en && hit_ptr)
    begin
      ptr_q <= wdata;
    end
    else if (data_rd && auto_inc)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Sticky refused-write flag; a new refusal beats a clear in one cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wr_ign_q <= 1'b0;
    end
    else if (err_wr)
    begin
      wr_ign_q <= 1'b1;
    end
    else if (wr_en && hit_stat && wdata[`SFDP_STAT_WR_IGN])
    begin
      wr_ign_q <= 1'b0;
    end
  end

  // Walk outcome flags, set by the walk and cleared by writing ones.
  // The setting edge wins over a clear arriving in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else
    begin
      if (walk_hit)
      begin
        done_q <= 1'b1;
      end
      else if (wr_en && hit_stat && wdata[`SFDP_STAT_DONE])
      begin
        done_q <= 1'b0;
      end
      if (walk_end)
      begin
        fail_q <= 1'b1;
      end
      else if (wr_en && hit_stat && wdata[`SFDP_STAT_FAIL])
      begin
        fail_q <= 1'b0;
      end
    end
  end

  // Location at which the walk found the discovery parameter.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      found_q <= `SFDP_FOUND_RST;
    end
    else if (walk_hit)
    begin
      found_q <= loc_q[7:0];
    end
  end

  // The walk follows identifiers and lengths the same way a host must,
  // which proves the padding chain actually leads to the table.
  assign walk_start = wr_en && hit_cmd && wdata[`SFDP_CMD_WALK];
  assign walk_idx   = (walk_q == sfdp_pkg::W_LEN) ? loc_q[7:0] + 8'h01
                                                  : loc_q[7:0];
  assign next_loc   = loc_q + {1'b0, walk_byte} + 9'h002;
  assign walk_hit   = (walk_q == sfdp_pkg::W_ID)
                      && (walk_byte == `SFDP_PARAM_ID);
  assign walk_end   = ((walk_q == sfdp_pkg::W_ID)
                       && (walk_byte != `SFDP_PARAM_ID)
                       && (walk_byte != `SFDP_PAD_ID))
                      || ((walk_q == sfdp_pkg::W_LEN)
                          && next_loc[8]);
  assign walk_busy  = (walk_q == sfdp_pkg::W_ID)
                      || (walk_q == sfdp_pkg::W_LEN);

  // Next walk state and location.
  always_comb
  begin
    walk_d = walk_q;
    loc_d  = loc_q;
    unique case (walk_q)
      sfdp_pkg::W_IDLE, sfdp_pkg::W_DONE, sfdp_pkg::W_FAIL:
      begin
        if (walk_start)
        begin
          walk_d = sfdp_pkg::W_ID;
          loc_d  = 9'h000;
        end
      end
      sfdp_pkg::W_ID:
      begin
        if (walk_hit)
        begin
          walk_d = sfdp_pkg::W_DONE;
        end
        else if (walk_end)
        begin
          walk_d = sfdp_pkg::W_FAIL;
        end
        else
        begin
          walk_d = sfdp_pkg::W_LEN;
        end
      end
      sfdp_pkg::W_LEN:
      begin
        if (walk_end)
        begin
          walk_d = sfdp_pkg::W_FAIL;
        end
        else
        begin
          walk_d = sfdp_pkg::W_ID;
          loc_d  = next_loc;
        end
      end
    endcase
  end

  // Walk state registers.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      walk_q <= sfdp_pkg::W_IDLE;
      loc_q  <= 9'h000;
    end
    else
    begin
      walk_q <= walk_d;
      loc_q  <= loc_d;
    end
  end

  // Read multiplexer. A hidden map reads as erased bytes so that a host
  // probing while map enable is clear sees no valid identifier.
  always_comb
  begin
    rdata_d = `SFDP_UNMAPPED;
    if (in_win || hit_data)
    begin
      rdata_d = map_en ? bus_byte : `SFDP_ERASED;
    end
    else if (hit_ctrl)
    begin
      rdata_d = ctrl_q;
    end
    else if (hit_ptr)
    begin
      rdata_d = ptr_q;
    end
    else if (hit_stat)
    begin
      rdata_d = {4'h0, fail_q, done_q, walk_busy, wr_ign_q};
    end
    else if (hit_found)
    begin
      rdata_d = found_q;
    end
    else if (hit_loc_lo)
    begin
      rdata_d = TABLE_LOC[7:0];
    end
    else if (hit_loc_hi)
    begin
      rdata_d = TABLE_LOC[15:8];
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rdata_q <= 8'h00;
    end
    else if (rd_en)
    begin
      rdata_q <= rdata_d;
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule
`default_nettype wire

// ---- bench/sfdp_param_table_props.sv ----
// Concurrent checks on the parameter table ports.
`default_nettype none
module sfdp_param_table_props #(
  parameter int       PAD_NUM = 1,
  parameter bit [7:0] PAD_LEN = 8'h0F
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic        walk_busy
);
  localparam int BASE = PAD_NUM * (PAD_LEN + 2);
  logic       map_en_q;
  logic [7:0] run_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Shadow of the map enable, so window checks know what to expect.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn) map_en_q <= 1'b1;
    else if (wr_en && addr == 12'h100) map_en_q <= wdata[0];
  end

  // Length of the current self walk in cycles.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || !walk_busy) run_q <= 8'h00;
    else run_q <= run_q + 8'h01;
  end

  // Basic table bytes by table offset.
  function automatic logic [7:0] tbl(input int i);
    case (i)
      0: return 8'hE7;
      2: return 8'hF3;
      7: return 8'h07;
      8: return 8'h44;
      9: return 8'hEB;
      10: return 8'h08;
      11: return 8'h6B;
      default: return 8'hFF;
    endcase
  endfunction

  AST_PAD_ID: assert property (
    rd_en && map_en_q && addr == 12'h000 |=> rdata == 8'hF0)
    else $error("pad id wrong");
  AST_PARAM_ID: assert property (
    rd_en && map_en_q && addr == BASE |=> rdata == 8'hA5)
    else $error("param id wrong");
  AST_PARAM_LEN: assert property (
    rd_en && map_en_q && addr == BASE + 1 |=> rdata == 8'h80)
    else $error("param length wrong");
  AST_TABLE_START: assert property (
    rd_en && map_en_q && addr == BASE + 2 |=> rdata == 8'hE7)
    else $error("table start wrong");
  AST_TABLE_BYTES: assert property (
    rd_en && map_en_q && addr >= BASE + 2 && addr <= BASE + 13
    |=> rdata == tbl(int'($past(addr)) - BASE - 2))
    else $error("table byte wrong");
  AST_FIXED_CONTENT: assert property (
    (rd_en && addr <= 12'h0FF) ##1 (rd_en && $stable(addr))
    |=> rdata == $past(rdata))
    else $error("content changed");
  AST_MAP_OFF: assert property (
    rd_en && !map_en_q && addr <= 12'h0FF |=> rdata == 8'hFF)
    else $error("disabled map not erased");
  AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not cleared");
  AST_WALK_START: assert property (
    wr_en && addr == 12'h104 && wdata[0] && !walk_busy |=> walk_busy)
    else $error("walk did not start");
  AST_WALK_TIME: assert property (
    $fell(walk_busy) |-> run_q == 2 * PAD_NUM + 1)
    else $error("walk length wrong");
endmodule

bind sfdp_param_table sfdp_param_table_props #(
  .PAD_NUM(PAD_NUM),
  .PAD_LEN(PAD_LEN)
) u_props (
  .clk_sys  (clk_sys),
  .resetn   (resetn),
  .addr     (addr),
  .wdata    (wdata),
  .wr_en    (wr_en),
  .rd_en    (rd_en),
  .rdata    (rdata),
  .walk_busy(walk_busy)
);
`default_nettype wire

// ---- bench/sfdp_host.sv ----
// Host controller model that reads the parameter map over the register port.
`default_nettype none
module sfdp_host (
  input  wire logic        clk_sys,
  output logic      [11:0] addr,
  output logic      [7:0]  wdata,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    addr = 12'h000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // One write; released lines show the inverse so stale values never pass.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // n back to back reads of one address; d keeps the last answer.
  task automatic rd(input logic [11:0] a, input int n, output logic [7:0] d);
    int i;
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      if (i == n - 1)
      begin
        rd_en <= 1'b0;
        addr <= ~a;
      end
      #1 d = rdata;
    end
  endtask

  // Skip parameters by identifier and length until the A5h one is found.
  task automatic find_param(output logic [7:0] loc);
    logic [7:0] id;
    logic [7:0] len;
    loc = 8'h00;
    repeat (8)
    begin
      rd({4'h0, loc}, 1, id);
      if (id == 8'hA5) return;
      rd({4'h0, loc} + 12'h001, 1, len);
      loc = loc + len + 8'h02;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_sfdp_param_table.sv ----
// Self-checking bench for the discovery parameter table.
`default_nettype none
module tb_sfdp_param_table;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         PNUM = 2;
  localparam logic [7:0] PLEN = 8'h05;
  localparam int         BASE = PNUM * (PLEN + 2);
  logic        clk_sys;
  logic        resetn;
  logic [11:0] addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        walk_busy;
  logic [7:0]  d;
  logic [7:0]  loc;
  logic [31:0] dens;
  logic [11:0] a;
  int          n_fail;
  int          n_compared;
  int          cycles;

  sfdp_param_table #(.PAD_NUM(PNUM), .PAD_LEN(PLEN)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .walk_busy(walk_busy));

  sfdp_host host (
    .clk_sys(clk_sys), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

  // Clock at 40 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Expected map byte: pads first, then the A5h parameter, erased beyond.
  function automatic logic [7:0] exp_map(input int m);
    int o;
    if (m < BASE)
    begin
      o = m % (PLEN + 2);
      return (o == 0) ? 8'hF0 : (o == 1) ? PLEN : 8'hFF;
    end
    case (m - BASE)
      0: return 8'hA5;
      1: return 8'h80;
      2: return 8'hE7;
      4: return 8'hF3;
      9: return 8'h07;
      10: return 8'h44;
      11: return 8'hEB;
      12: return 8'h08;
      13: return 8'h6B;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    resetn = 1'b0;
    void'($urandom(32'h95fe_6569));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    host.rd(12'h100, 1, d);
    check("ctrl reset", d, 8'h01);
    host.find_param(loc);
    check("param location", loc, BASE);
    for (int i = 0; i < 14; i++)
    begin
      host.rd(12'(BASE + i), 1, d);
      check("param byte", d, exp_map(BASE + i));
    end
    // Density assembled least significant byte first.
    for (int i = 0; i < 4; i++)
    begin
      host.rd(12'(BASE + 6 + i), 1, d);
      dens = {d, dens[31:8]};
    end
    check("density", dens, 32'h07FF_FFFF);
    // Data port with auto increment walks the table from the pointer.
    host.wr(12'h101, 8'(BASE + 2));
    host.wr(12'h100, 8'h03);
    for (int i = 0; i < 12; i++)
    begin
      host.rd(12'h102, 1, d);
      check("data", d, exp_map(BASE + 2 + i));
    end
    host.rd(12'h101, 1, d);
    check("pointer", d, 8'(BASE + 14));
    host.wr(12'h100, 8'h01);
    // Writes into the window are refused; contents must stay put.
    repeat (40)
    begin
      a = 12'($urandom_range(0, 255));
      host.wr(a, 8'($urandom));
      host.rd(a, 2, d);
      check("window byte", d, exp_map(a));
      host.rd(12'($urandom_range(12'h108, 12'hFFF)), 1, d);
      check("unmapped", d, 8'h00);
    end
    // Refused writes leave a sticky flag that a written one clears.
    host.rd(12'h103, 1, d);
    check("refused flag", d[0], 1'b1);
    host.wr(12'h103, 8'h01);
    host.rd(12'h103, 1, d);
    check("refused clear", d[0], 1'b0);
    host.wr(12'h100, 8'h00);
    host.rd(12'(BASE), 1, d);
    check("map off", d, 8'hFF);
    host.wr(12'h100, 8'h01);
    host.wr(12'h104, 8'h01);
    #1 check("walk busy", walk_busy, 1'b1);
    repeat (2 * PNUM + 4) @(posedge clk_sys);
    host.rd(12'h105, 1, d);
    check("found", d, BASE);
    host.rd(12'h106, 1, d);
    check("loc low", d, 8'h20);
    host.rd(12'h107, 1, d);
    check("loc high", d, 8'h11);
    host.rd(12'h103, 1, d);
    check("walk found flag", d[2], 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
